/* hdl/sscr_pkg.sv */
/*
 sscr_pkg: register offsets, status bit positions, reset values and
 field layout of the serial controller register bank.
 assumes a 32-bit APB with byte addresses and word-aligned registers.
*/
package sscr_pkg;
	// register byte offsets
	localparam logic [7:0] SSCR_OFF_CTRL = 8'h00;
	localparam logic [7:0] SSCR_OFF_TX_HOLD = 8'h04;
	localparam logic [7:0] SSCR_OFF_RX_HOLD = 8'h08;
	localparam logic [7:0] SSCR_OFF_RX_SYNC = 8'h0c;
	localparam logic [7:0] SSCR_OFF_TX_SYNC = 8'h10;
	localparam logic [7:0] SSCR_OFF_CMP0 = 8'h14;
	localparam logic [7:0] SSCR_OFF_CMP1 = 8'h18;
	localparam logic [7:0] SSCR_OFF_STATUS = 8'h1c;
	localparam logic [7:0] SSCR_OFF_IER = 8'h20;
	localparam logic [7:0] SSCR_OFF_IDR = 8'h24;
	localparam logic [7:0] SSCR_OFF_IMR = 8'h28;
	localparam logic [7:0] SSCR_OFF_TX_CNT = 8'h2c;
	localparam logic [7:0] SSCR_OFF_TX_NCNT = 8'h30;
	localparam logic [7:0] SSCR_OFF_RX_CNT = 8'h34;
	localparam logic [7:0] SSCR_OFF_RX_NCNT = 8'h38;
	localparam logic [7:0] SSCR_OFF_LAST = 8'h38;
	// status bit positions; those below SSCR_IRQ_W are shared by enable, disable and mask registers
	localparam int SSCR_B_TX_FREE = 0;
	localparam int SSCR_B_TX_DRAINED = 1;
	localparam int SSCR_B_TX_DONE = 2;
	localparam int SSCR_B_TX_BUFS_DONE = 3;
	localparam int SSCR_B_RX_AVAIL = 4;
	localparam int SSCR_B_RX_OVERRUN = 5;
	localparam int SSCR_B_RX_DONE = 6;
	localparam int SSCR_B_RX_BUFS_FULL = 7;
	localparam int SSCR_B_CMP_FIRST = 8;
	localparam int SSCR_B_CMP_SECOND = 9;
	localparam int SSCR_B_TX_FS_SEEN = 10;
	localparam int SSCR_B_RX_FS_SEEN = 11;
	localparam int SSCR_B_TX_ON = 16;
	localparam int SSCR_B_RX_ON = 17;
	localparam int SSCR_IRQ_W = 12;
	// control register fields
	localparam int SSCR_C_TX_ON = 0;
	localparam int SSCR_C_RX_ON = 1;
	localparam int SSCR_C_LEN_LO = 8;
	localparam int SSCR_C_LEN_HI = 12;
	// reset values
	localparam logic [31:0] SSCR_RST_WORD = 32'h0000_0000;
	localparam logic [4:0] SSCR_RST_LEN = 5'h07;
	localparam logic [15:0] SSCR_RST_CNT = 16'h0000;
	localparam logic [11:0] SSCR_RST_MASK = 12'h000;
endpackage

/* hdl/sscr_sync.sv */
/*
 sscr_sync: two-flop synchroniser for pins from outside the pclk domain.
 assumes each bit is an independent level; no bus coherency is given.
*/
`timescale 1ns/10ps
`default_nettype none
module sscr_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins in, synchronised levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// meta_reg feeds only the second flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* hdl/sscr_shift.sv */
/*
 sscr_shift: shift register shared by transmit and receive paths.
 shifts left, serial_in enters at bit 0, word ends right aligned.
 assumes step is a single-cycle pulse and last_idx is stable in a word.
*/
`timescale 1ns/10ps
`default_nettype none
module sscr_shift (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic load,
	input wire logic [31:0] load_word,
	input wire logic step,
	input wire logic serial_in,
	input wire logic [4:0] last_idx,
	// state
	output logic [31:0] word,
	output logic busy,
	output logic done
);
	logic [4:0] cnt_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			word <= 32'h0000_0000;
			cnt_reg <= 5'h00;
			busy <= 1'b0;
		end else if (load) begin
			word <= load_word;
			cnt_reg <= 5'h00;
			busy <= 1'b1;
		end else if (step) begin
			word <= {word[30:0], serial_in};
			if (cnt_reg == last_idx) begin
				cnt_reg <= 5'h00;
				busy <= 1'b0;
			end else begin
				cnt_reg <= cnt_reg + 5'h01;
			end
		end
	end

	// done rises one cycle after the last step, when word is complete
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
		end else begin
			done <= step && !load && (cnt_reg == last_idx);
		end
	end
endmodule
`default_nettype wire

/* hdl/sscr_top.sv */
/*
 sscr_top: register bank of a synchronous serial controller on APB,
 with a small msb-first serial path so the status flags carry meaning.
 assumes link_clk and the frame-sync and data pins are asynchronous to
 pclk and slower than a quarter of it; DMA counters are loaded by software.
*/
`timescale 1ns/10ps
`default_nettype none
module sscr_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	input wire logic link_clk,
	input wire logic tx_frame_sync_in,
	input wire logic rx_frame_sync_in,
	input wire logic rx_data_in,
	output logic tx_data_out,
	// interrupt
	output logic irq
);
	import sscr_pkg::*;

	// returns {counter, next counter} after one transfer
	function automatic logic [31:0] dma_step(input logic [15:0] c,
		input logic [15:0] n);
		logic [31:0] r;
		r = {c, n};
		if (c == 16'h0001 && n != 16'h0000) begin
			r = {n, 16'h0000};
		end else if (c != 16'h0000) begin
			r = {c - 16'h0001, n};
		end
		return r;
	endfunction

	// apb decode
	logic wr;
	logic rd;
	logic mapped;
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= SSCR_OFF_LAST);

	logic [31:0] ctrl_reg;
	logic [31:0] tx_hold_reg;
	logic [31:0] rx_hold_reg;
	logic [15:0] rx_sync_reg;
	logic [15:0] tx_sync_reg;
	logic [15:0] cmp0_reg;
	logic [15:0] cmp1_reg;
	logic [11:0] mask_reg;
	logic [15:0] tx_cnt_reg;
	logic [15:0] tx_ncnt_reg;
	logic [15:0] rx_cnt_reg;
	logic [15:0] rx_ncnt_reg;
	logic tx_full_reg;
	logic rx_avail_reg;
	logic ovr_reg;
	logic tx_end_reg;
	logic rx_end_reg;
	logic cmp_first_reg;
	logic cmp_second_reg;
	logic tx_fs_seen_reg;
	logic rx_fs_seen_reg;
	logic [3:0] pin_prev_reg;
	logic [31:0] status;

	logic tx_en;
	logic rx_en;
	logic [4:0] last_idx;
	assign tx_en = ctrl_reg[SSCR_C_TX_ON];
	assign rx_en = ctrl_reg[SSCR_C_RX_ON];
	assign last_idx = ctrl_reg[SSCR_C_LEN_HI:SSCR_C_LEN_LO];

	// link pins: {rx data, rx sync, tx sync, link clock}
	logic [3:0] pin_s;
	sscr_sync #(.WIDTH(4)) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.async_in({rx_data_in, rx_frame_sync_in, tx_frame_sync_in, link_clk}),
		.sync_out(pin_s)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_reg <= 4'h0;
		end else begin
			pin_prev_reg <= pin_s;
		end
	end

	logic lk_rise;
	logic lk_fall;
	logic txfs_rise;
	logic rxfs_rise;
	assign lk_rise = pin_s[0] && !pin_prev_reg[0];
	assign lk_fall = !pin_s[0] && pin_prev_reg[0];
	assign txfs_rise = pin_s[1] && !pin_prev_reg[1];
	assign rxfs_rise = pin_s[2] && !pin_prev_reg[2];

	// transmit path: data changes on falling link edges
	logic tx_load;
	logic [31:0] tx_word;
	logic tx_busy;
	assign tx_load = tx_full_reg && !tx_busy && tx_en;
	sscr_shift u_tx (
		.clk(pclk),
		.rst_n(presetn),
		.load(tx_load),
		.load_word(tx_hold_reg),
		.step(lk_fall && tx_busy),
		.serial_in(1'b0),
		.last_idx(last_idx),
		.word(tx_word),
		.busy(tx_busy),
		.done()
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data_out <= 1'b0;
		end else begin
			// a reload shows its first bit at once, so words run back to back
			tx_data_out <= tx_load ? tx_hold_reg[last_idx] : (tx_busy ? tx_word[last_idx] : 1'b0);
		end
	end

	// receive path: sampled on rising link edges outside frame sync
	logic [31:0] rx_word;
	logic rx_done;
	sscr_shift u_rx (
		.clk(pclk),
		.rst_n(presetn),
		.load(1'b0),
		.load_word(SSCR_RST_WORD),
		.step(lk_rise && rx_en && !pin_s[2]),
		.serial_in(pin_s[3]),
		.last_idx(last_idx),
		.word(rx_word),
		.busy(),
		.done(rx_done)
	);

	logic [31:0] rx_aligned;
	assign rx_aligned = rx_word & (32'hffff_ffff >> (5'd31 - last_idx));

	// bits seen while rx sync is high form the rx sync word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sync_reg <= SSCR_RST_CNT;
		end else if (lk_rise && rx_en && pin_s[2]) begin
			rx_sync_reg <= {rx_sync_reg[14:0], pin_s[3]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_hold_reg <= SSCR_RST_WORD;
		end else if (rx_done) begin
			rx_hold_reg <= rx_aligned;
		end
	end

	// software registers
	logic tx_wr;
	logic tx_cnt_wr;
	logic rx_cnt_wr;
	assign tx_wr = wr && paddr == SSCR_OFF_TX_HOLD;
	assign tx_cnt_wr = wr && (paddr == SSCR_OFF_TX_CNT || paddr == SSCR_OFF_TX_NCNT);
	assign rx_cnt_wr = wr && (paddr == SSCR_OFF_RX_CNT || paddr == SSCR_OFF_RX_NCNT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= {19'h0_0000, SSCR_RST_LEN, 8'h00};
			tx_hold_reg <= SSCR_RST_WORD;
			tx_sync_reg <= SSCR_RST_CNT;
			cmp0_reg <= SSCR_RST_CNT;
			cmp1_reg <= SSCR_RST_CNT;
		end else if (wr) begin
			case (paddr)
				SSCR_OFF_CTRL: ctrl_reg <= {19'h0_0000, pwdata[12:8], 6'h00, pwdata[1:0]};
				SSCR_OFF_TX_HOLD: tx_hold_reg <= pwdata;
				SSCR_OFF_TX_SYNC: tx_sync_reg <= pwdata[15:0];
				SSCR_OFF_CMP0: cmp0_reg <= pwdata[15:0];
				SSCR_OFF_CMP1: cmp1_reg <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// a 1 in enable sets, in disable clears; zeros leave the mask alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= SSCR_RST_MASK;
		end else if (wr && paddr == SSCR_OFF_IER) begin
			mask_reg <= mask_reg | pwdata[SSCR_IRQ_W-1:0];
		end else if (wr && paddr == SSCR_OFF_IDR) begin
			mask_reg <= mask_reg & ~pwdata[SSCR_IRQ_W-1:0];
		end
	end

	// dma counters: tx counts holding writes, rx counts received words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_cnt_reg <= SSCR_RST_CNT;
			tx_ncnt_reg <= SSCR_RST_CNT;
		end else if (wr && paddr == SSCR_OFF_TX_CNT) begin
			tx_cnt_reg <= pwdata[15:0];
		end else if (wr && paddr == SSCR_OFF_TX_NCNT) begin
			tx_ncnt_reg <= pwdata[15:0];
		end else if (tx_wr) begin
			{tx_cnt_reg, tx_ncnt_reg} <= dma_step(tx_cnt_reg, tx_ncnt_reg);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_cnt_reg <= SSCR_RST_CNT;
			rx_ncnt_reg <= SSCR_RST_CNT;
		end else if (wr && paddr == SSCR_OFF_RX_CNT) begin
			rx_cnt_reg <= pwdata[15:0];
		end else if (wr && paddr == SSCR_OFF_RX_NCNT) begin
			rx_ncnt_reg <= pwdata[15:0];
		end else if (rx_done) begin
			{rx_cnt_reg, rx_ncnt_reg} <= dma_step(rx_cnt_reg, rx_ncnt_reg);
		end
	end
	// end flags: set when a transfer finds the counter at one, whether it then reaches zero or reloads
	logic tx_end_set;
	logic rx_end_set;
	assign tx_end_set = tx_wr && tx_cnt_reg == 16'h0001;
	assign rx_end_set = rx_done && !rx_cnt_wr && rx_cnt_reg == 16'h0001;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_end_reg <= 1'b0;
			rx_end_reg <= 1'b0;
		end else begin
			tx_end_reg <= tx_end_set || (tx_end_reg && !tx_cnt_wr);
			rx_end_reg <= rx_end_set || (rx_end_reg && !rx_cnt_wr);
		end
	end

	// holding flags
	logic rx_rd;
	assign rx_rd = rd && paddr == SSCR_OFF_RX_HOLD;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_full_reg <= 1'b0;
			rx_avail_reg <= 1'b0;
		end else begin
			tx_full_reg <= tx_wr || (tx_full_reg && !tx_load);
			rx_avail_reg <= rx_done || (rx_avail_reg && !rx_rd);
		end
	end

	// read-clear flags drop only the bits the status read reported,
	// so an event landing between setup and access is not lost
	logic st_rd;
	logic [31:0] seen;
	assign st_rd = rd && paddr == SSCR_OFF_STATUS;
	assign seen = st_rd ? prdata : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovr_reg <= 1'b0;
			cmp_first_reg <= 1'b0;
			cmp_second_reg <= 1'b0;
			tx_fs_seen_reg <= 1'b0;
			rx_fs_seen_reg <= 1'b0;
		end else begin
			ovr_reg <= (rx_done && rx_avail_reg && !rx_rd)
				|| (ovr_reg && !seen[SSCR_B_RX_OVERRUN]);
			cmp_first_reg <= (rx_done && rx_aligned[15:0] == cmp0_reg)
				|| (cmp_first_reg && !seen[SSCR_B_CMP_FIRST]);
			cmp_second_reg <= (rx_done && rx_aligned[15:0] == cmp1_reg)
				|| (cmp_second_reg && !seen[SSCR_B_CMP_SECOND]);
			tx_fs_seen_reg <= txfs_rise
				|| (tx_fs_seen_reg && !seen[SSCR_B_TX_FS_SEEN]);
			rx_fs_seen_reg <= rxfs_rise
				|| (rx_fs_seen_reg && !seen[SSCR_B_RX_FS_SEEN]);
		end
	end

	always_comb begin
		status = 32'h0000_0000;
		status[SSCR_B_TX_FREE] = !tx_full_reg;
		status[SSCR_B_TX_DRAINED] = !tx_full_reg && !tx_busy;
		status[SSCR_B_TX_DONE] = tx_end_reg;
		status[SSCR_B_TX_BUFS_DONE] = tx_cnt_reg == 16'h0000 && tx_ncnt_reg == 16'h0000;
		status[SSCR_B_RX_AVAIL] = rx_avail_reg;
		status[SSCR_B_RX_OVERRUN] = ovr_reg;
		status[SSCR_B_RX_DONE] = rx_end_reg;
		status[SSCR_B_RX_BUFS_FULL] = rx_cnt_reg == 16'h0000 && rx_ncnt_reg == 16'h0000;
		status[SSCR_B_CMP_FIRST] = cmp_first_reg;
		status[SSCR_B_CMP_SECOND] = cmp_second_reg;
		status[SSCR_B_TX_FS_SEEN] = tx_fs_seen_reg;
		status[SSCR_B_RX_FS_SEEN] = rx_fs_seen_reg;
		status[SSCR_B_TX_ON] = tx_en;
		status[SSCR_B_RX_ON] = rx_en;
	end
	// read mux; write-only registers read as zero
	logic [31:0] rdata;
	always_comb begin
		case (paddr)
			SSCR_OFF_CTRL: rdata = ctrl_reg;
			SSCR_OFF_RX_HOLD: rdata = rx_hold_reg;
			SSCR_OFF_RX_SYNC: rdata = {16'h0000, rx_sync_reg};
			SSCR_OFF_TX_SYNC: rdata = {16'h0000, tx_sync_reg};
			SSCR_OFF_CMP0: rdata = {16'h0000, cmp0_reg};
			SSCR_OFF_CMP1: rdata = {16'h0000, cmp1_reg};
			SSCR_OFF_STATUS: rdata = status;
			SSCR_OFF_IMR: rdata = {20'h0_0000, mask_reg};
			SSCR_OFF_TX_CNT: rdata = {16'h0000, tx_cnt_reg};
			SSCR_OFF_TX_NCNT: rdata = {16'h0000, tx_ncnt_reg};
			SSCR_OFF_RX_CNT: rdata = {16'h0000, rx_cnt_reg};
			SSCR_OFF_RX_NCNT: rdata = {16'h0000, rx_ncnt_reg};
			default: rdata = 32'h0000_0000;
		endcase
	end

	// one wait-free access phase: data and ready registered in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= (!pwrite && mapped) ? rdata : 32'h0000_0000;
			pready <= 1'b1;
			pslverr <= !mapped;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status[SSCR_IRQ_W-1:0] & mask_reg);
		end
	end
endmodule
`default_nettype wire

/* verification/sscr_top_chk.sv */
/*
 sscr_top_chk: port-level assertions on the register bank's apb side.
 assumes one pclk domain and the zero-wait apb slave of the hand-over.
*/
`timescale 1ns/10ps
`default_nettype none
module sscr_top_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// interrupt
	input wire logic irq
);
	import sscr_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic setup;
	logic rd_setup;
	logic bad_addr;
	assign setup = psel && !penable;
	assign rd_setup = setup && !pwrite;
	assign bad_addr = paddr > SSCR_OFF_LAST || paddr[1:0] != 2'b00;
	a_ready_after_setup: assert property (setup |=> pready)
		else $error("pready missing after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_bad_addr_err: assert property (setup && bad_addr |=>
		pslverr && (pwrite || prdata == 32'h0000_0000))
		else $error("unmapped access not refused");
	a_good_addr_ok: assert property (setup && !bad_addr |=> !pslverr)
		else $error("error on mapped access");
	a_rsync_upper: assert property (
		rd_setup && paddr == SSCR_OFF_RX_SYNC |=> prdata[31:16] == 16'h0000)
		else $error("rx sync word upper bits set");
	a_cmp_upper: assert property (
		rd_setup && (paddr == SSCR_OFF_CMP0 || paddr == SSCR_OFF_CMP1)
		|=> prdata[31:16] == 16'h0000)
		else $error("compare upper bits set");
	a_status_rsvd: assert property (
		rd_setup && paddr == SSCR_OFF_STATUS
		|=> prdata[31:18] == 14'h0000 && prdata[15:12] == 4'h0)
		else $error("status reserved bits set");
	a_mask_width: assert property (
		rd_setup && paddr == SSCR_OFF_IMR |=> prdata[31:12] == 20'h0_0000)
		else $error("mask reserved bits set");
	a_wo_read_zero: assert property (
		rd_setup && (paddr == SSCR_OFF_IER || paddr == SSCR_OFF_IDR
		|| paddr == SSCR_OFF_TX_HOLD) |=> prdata == 32'h0000_0000)
		else $error("write-only register reads nonzero");
	a_irq_all_off: assert property (
		psel && penable && pready && pwrite && paddr == SSCR_OFF_IDR
		&& pwdata[11:0] == 12'hfff |-> ##2 !irq)
		else $error("irq high after all sources disabled");
endmodule
bind sscr_top sscr_top_chk u_sscr_top_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq(irq));
`default_nettype wire

/* verification/sscr_codec.sv */
/*
 sscr_codec: behavioural serial codec on the block's link pins.
 assumes the caller runs one frame at a time; the clock stands low between frames.
*/
`timescale 1ns/10ps
`default_nettype none
module sscr_codec (
	// pins toward the block
	output logic link_clk,
	output logic tx_fs,
	output logic rx_fs,
	output logic rx_dat,
	// serial data from the block
	input wire logic tx_dat
);
	initial begin
		link_clk = 1'b0;
		tx_fs = 1'b0;
		rx_fs = 1'b0;
		rx_dat = 1'b0;
	end
	// msb first; odd start offset keeps link edges off the pclk grid
	task automatic frame(input logic [15:0] s, input int n, output logic [15:0] g);
		g = 16'h0000;
		#13;
		for (int i = n - 1; i >= 0; i--) begin
			rx_dat = s[i];
			#200 link_clk = 1'b1;
			g = {g[14:0], tx_dat};
			#200 link_clk = 1'b0;
		end
		// released line must not keep looking valid
		rx_dat = ~rx_dat;
	endtask
	task automatic sync_pulse();
		tx_fs = 1'b1;
		rx_fs = 1'b1;
		#400 tx_fs = 1'b0;
		rx_fs = 1'b0;
	endtask
endmodule
`default_nettype wire

/* verification/sscr_top_tb.sv */
/*
 sscr_top_tb: self-checking bench for the serial register bank.
 assumes the codec model on the link pins and byte-addressed apb.
*/
`timescale 1ns/10ps
`default_nettype none
module sscr_top_tb;
	import sscr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] got;
	wire link_clk, tx_fs, rx_fs, rx_dat, tx_dat;
	int mismatches, n_checks, cyc;
	sscr_top u_sscr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_clk(link_clk), .tx_frame_sync_in(tx_fs),
		.rx_frame_sync_in(rx_fs), .rx_data_in(rx_dat),
		.tx_data_out(tx_dat), .irq(irq));
	sscr_codec u_sscr_codec (.link_clk(link_clk), .tx_fs(tx_fs),
		.rx_fs(rx_fs), .rx_dat(rx_dat), .tx_dat(tx_dat));
	task conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) mismatches++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	task t_reset();
		rdc(SSCR_OFF_STATUS, 32'h0000_008b);
		rdc(SSCR_OFF_IMR, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
	endtask
	task t_regs();
		wr(SSCR_OFF_CMP0, 32'hffff_ffff);
		rdc(SSCR_OFF_CMP0, 32'h0000_ffff);
		wr(SSCR_OFF_CMP1, 32'h0000_1234);
		rdc(SSCR_OFF_CMP1, 32'h0000_1234);
		wr(SSCR_OFF_RX_SYNC, 32'h0000_ffff);
		rdc(SSCR_OFF_RX_SYNC, 32'h0000_0000);
		rdc(SSCR_OFF_TX_HOLD, 32'h0000_0000);
		rdc(SSCR_OFF_IDR, 32'h0000_0000);
		wr(8'h3c, 32'h0000_0001);
		chk({31'h0, err}, 32'h0000_0001);
		bus(1'b0, 8'h02, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
	endtask
	task t_irq();
		wr(SSCR_OFF_IER, 32'h0000_0f0f);
		rdc(SSCR_OFF_IMR, 32'h0000_0f0f);
		wr(SSCR_OFF_IER, 32'h0000_0000);
		rdc(SSCR_OFF_IER, 32'h0000_0000);
		wr(SSCR_OFF_IDR, 32'h0000_0005);
		rdc(SSCR_OFF_IMR, 32'h0000_0f0a);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(SSCR_OFF_IDR, 32'h0000_0fff);
		rdc(SSCR_OFF_IMR, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
	endtask
	task t_sync();
		wr(SSCR_OFF_IER, 32'h0000_0800);
		u_sscr_codec.sync_pulse();
		repeat (8) @(posedge pclk);
		chk({31'h0, irq}, 32'h0000_0001);
		bus(1'b0, SSCR_OFF_STATUS, 32'h0000_0000);
		chk(rd & 32'h0000_0c00, 32'h0000_0c00);
		rdc(SSCR_OFF_STATUS, 32'h0000_008b);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(SSCR_OFF_IDR, 32'h0000_0800);
	endtask
	task t_tx();
		wr(SSCR_OFF_CTRL, 32'h0000_0701);
		wr(SSCR_OFF_TX_CNT, 32'h0000_0002);
		rdc(SSCR_OFF_STATUS, 32'h0001_0083);
		wr(SSCR_OFF_TX_HOLD, 32'h0000_015a);
		wr(SSCR_OFF_TX_HOLD, 32'h0000_00c3);
		rdc(SSCR_OFF_STATUS, 32'h0001_008c);
		u_sscr_codec.frame(16'h0000, 16, got);
		chk({16'h0000, got}, 32'h0000_5ac3);
		repeat (8) @(posedge pclk);
		rdc(SSCR_OFF_STATUS, 32'h0001_008f);
		wr(SSCR_OFF_TX_CNT, 32'h0000_0000);
		rdc(SSCR_OFF_STATUS, 32'h0001_008b);
		wr(SSCR_OFF_CTRL, 32'h0000_0700);
	endtask
	task t_rx();
		wr(SSCR_OFF_CTRL, 32'h0000_0702);
		wr(SSCR_OFF_CMP0, 32'h0000_00a5);
		wr(SSCR_OFF_RX_CNT, 32'h0000_0002);
		u_sscr_codec.frame(16'h00a5, 8, got);
		repeat (8) @(posedge pclk);
		u_sscr_codec.frame(16'h003c, 8, got);
		repeat (8) @(posedge pclk);
		rdc(SSCR_OFF_STATUS, 32'h0002_01fb);
		rdc(SSCR_OFF_STATUS, 32'h0002_00db);
		rdc(SSCR_OFF_RX_HOLD, 32'h0000_003c);
		rdc(SSCR_OFF_STATUS, 32'h0002_00cb);
		wr(SSCR_OFF_RX_CNT, 32'h0000_0000);
		rdc(SSCR_OFF_STATUS, 32'h0002_008b);
		wr(SSCR_OFF_CTRL, 32'h0000_0700);
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// hang guard: whole run needs well under two thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_irq();
		t_sync();
		t_tx();
		t_rx();
		conclude();
	end
endmodule
`default_nettype wire
